// ==== universal_shift_storage_register_tb_top.sv ====
`timescale 1ns/100ps
module universal_shift_storage_register_tb_top;
   import uss_pkg::*;
   logic               CLOCK, RST_N, PSEL, PENABLE, PWRITE;
   logic [APB_AW-1:0]  PADDR;
   logic [APB_DW-1:0]  PWDATA, PRDATA;
   logic               PREADY, PSLVERR;
   logic               SHIFT_CLOCK, MASTER_RESET_N, MODE_SEL_0, MODE_SEL_1;
   logic               RIGHT_SERIAL_IN, LEFT_SERIAL_IN, OUT_EN_A_N, OUT_EN_B_N;
   logic [STAGE_W-1:0] bus_in, bus_out, drive_val, exp;
   logic               bus_oe, first_out, last_out, drive_en, clash, clash_seen;
   logic [31:0]        rd;
   logic               err;
   int                 error_cnt, samples_checked, cyc;
   // =======================================================
   // Instances
   uss_top dut
   (
      .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .SHIFT_CLOCK(SHIFT_CLOCK), .MASTER_RESET_N(MASTER_RESET_N),
      .MODE_SEL_0(MODE_SEL_0), .MODE_SEL_1(MODE_SEL_1),
      .RIGHT_SERIAL_IN(RIGHT_SERIAL_IN), .LEFT_SERIAL_IN(LEFT_SERIAL_IN),
      .OUT_EN_A_N(OUT_EN_A_N), .OUT_EN_B_N(OUT_EN_B_N), .PARALLEL_BUS_IN(bus_in),
      .PARALLEL_BUS_OUT(bus_out), .PARALLEL_BUS_OE(bus_oe),
      .FIRST_STAGE_OUT(first_out), .LAST_STAGE_OUT(last_out)
   );
   uss_bus_partner partner
   (
      .clock(CLOCK), .dev_out(bus_out), .dev_oe(bus_oe), .drive_en(drive_en),
      .drive_val(drive_val), .bus_level(bus_in), .clash(clash)
   );
   // =======================================================
   // Clock, timeout, contention watch
   initial
   begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK)
   begin
      cyc++;
      if (clash === 1'b1)
         clash_seen = 1'b1;
      if (cyc == 5000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   // =======================================================
   // Tasks
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask
   // Zero wait states are not assumed: access lasts until PREADY
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      while (PREADY !== 1'b1)
         @(posedge CLOCK);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // One shift clock pulse; mode and data settle well before the edge
   task automatic shift(input logic [1:0] m, input logic r, input logic l);
      @(posedge CLOCK);
      {MODE_SEL_1, MODE_SEL_0} <= m;
      RIGHT_SERIAL_IN <= r;
      LEFT_SERIAL_IN <= l;
      repeat (5) @(posedge CLOCK);
      if (m == USS_LOAD)
         chk(bus_oe, 1'b0);
      drive_en <= (m == USS_LOAD);
      repeat (3) @(posedge CLOCK);
      SHIFT_CLOCK <= 1'b1;
      repeat (3) @(posedge CLOCK);
      SHIFT_CLOCK <= 1'b0;
      drive_en <= 1'b0;
      repeat (4) @(posedge CLOCK);
      case (m)
         USS_SHR:  exp = {exp[6:0], r};
         USS_SHL:  exp = {l, exp[7:1]};
         USS_LOAD: exp = drive_val;
         default:  exp = exp;
      endcase
   endtask
   task automatic chk_stage();
      chk(first_out, exp[0]);
      chk(last_out, exp[7]);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[7:0], exp);
   endtask
   task automatic chk_oe(input logic a, input logic b, input logic want);
      @(posedge CLOCK);
      OUT_EN_A_N <= a;
      OUT_EN_B_N <= b;
      repeat (5) @(posedge CLOCK);
      chk(bus_oe, want);
      if (want)
         chk(bus_out, exp);
   endtask
   // =======================================================
   // Main sequence
   initial
   begin
      {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      {SHIFT_CLOCK, MODE_SEL_0, MODE_SEL_1, RIGHT_SERIAL_IN, LEFT_SERIAL_IN} = '0;
      {OUT_EN_A_N, OUT_EN_B_N, drive_en, clash_seen} = '0;
      MASTER_RESET_N = 1'b1;
      drive_val = 8'ha5;
      exp = 8'h00;
      repeat (2) @(posedge CLOCK);
      RST_N <= 1'b1;
      chk_stage();
      chk(rd, 32'h100);
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      chk(PREADY, 1'b1);
      chk_oe(1'b0, 1'b0, 1'b1);
      shift(USS_LOAD, 1'b0, 1'b0);
      chk_stage();
      shift(USS_HOLD, 1'b1, 1'b1);
      chk_stage();
      chk_oe(1'b0, 1'b0, 1'b1);
      shift(USS_SHR, 1'b0, 1'b1);
      chk_stage();
      shift(USS_SHR, 1'b1, 1'b0);
      chk_stage();
      shift(USS_SHL, 1'b0, 1'b1);
      chk_stage();
      shift(USS_SHL, 1'b1, 1'b0);
      chk_stage();
      shift(USS_SHL, 1'b0, first_out);
      chk_stage();
      shift(USS_SHR, last_out, 1'b0);
      chk_stage();
      chk_oe(1'b1, 1'b0, 1'b0);
      shift(USS_SHR, 1'b1, 1'b0);
      chk_stage();
      chk_oe(1'b0, 1'b1, 1'b0);
      chk_oe(1'b0, 1'b0, 1'b1);
      @(posedge CLOCK);
      MASTER_RESET_N <= 1'b0;
      @(posedge CLOCK);
      #1;
      chk({first_out, last_out, bus_out}, 10'h0);
      @(posedge CLOCK);
      MASTER_RESET_N <= 1'b1;
      exp = 8'h00;
      // Capture FIFO: overfill, then drain
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (10) shift(USS_SHR, 1'b1, 1'b0);
      chk_stage();
      chk(rd, 32'h6ff);
      for (int k = 0; k < 9; k++)
      begin
         apb(1'b0, OFS_DATA, 32'h0);
         chk(rd[8:0], (k < 8) ? (32'h100 | ((32'h1 << (k + 1)) - 1)) : 32'h1ff);
      end
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd[8], 1'b0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h5ff);
      apb(1'b1, OFS_STATUS, 32'h400);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h1ff);
      chk(clash_seen, 1'b0);
      finish_test();
   end
endmodule

// ==== uss_bus_partner.sv ====
`timescale 1ns/100ps
module uss_bus_partner
   import uss_pkg::*;
(
   // Clock
   input  wire logic                        clock,
   // Device side of the bus
   input  wire logic [uss_pkg::STAGE_W-1:0] dev_out,
   input  wire logic                        dev_oe,
   // Outside logic drive request
   input  wire logic                        drive_en,
   input  wire logic [uss_pkg::STAGE_W-1:0] drive_val,
   // Resolved bus level and fault flag
   output logic      [uss_pkg::STAGE_W-1:0] bus_level,
   output logic                             clash
);
   import uss_pkg::*;
   logic [STAGE_W-1:0] last_reg;
   // =======================================================
   // Bus resolution
   // No pull on the bus, so a floating bus shows a pattern that flips every cycle
   assign bus_level = dev_oe ? dev_out : (drive_en ? drive_val : ~last_reg);
   // Both parties driving at once is contention
   assign clash = dev_oe & drive_en;
   always_ff @(posedge clock)
   begin
      last_reg <= bus_level;
   end
endmodule

// ==== uss_fifo.sv ====
`timescale 1ns/100ps
module uss_fifo
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
)
(
   // Clock and reset
   input wire logic    clock,
   input wire logic    rst_n,
   // Data path
   uss_fifo_if.store   port
);
   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(port.in_data) != WIDTH)
   begin : g_bad
      $error("uss_fifo: depth must be a power of two and width must match");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   wire              push = port.in_valid & port.in_ready;
   wire              pop  = port.out_valid & port.out_ready;

   assign port.in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign port.out_valid = (count_reg != '0);
   // Read word comes straight from the storage flops
   assign port.out_data  = mem_reg[rd_ptr_reg];
   assign count_next     = count_reg + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= port.in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         count_reg  <= count_next;
      end
   end

   a_fifo_no_overfill : assert property (@(posedge clock) disable iff (!rst_n)
      count_reg <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule

// ==== uss_fifo_if.sv ====
`timescale 1ns/100ps
interface uss_fifo_if #(parameter int unsigned WIDTH = 8);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;

   // Top fills and drains; the store holds
   modport client
   (
      output in_valid, in_data, out_ready,
      input  in_ready, out_valid, out_data
   );
   modport store
   (
      input  in_valid, in_data, out_ready,
      output in_ready, out_valid, out_data
   );
endinterface

// ==== uss_pkg.sv ====
package uss_pkg;

   // =======================================================
   // Widths
   localparam int unsigned STAGE_W   = 8;
   localparam int unsigned APB_AW    = 8;
   localparam int unsigned APB_DW    = 32;
   localparam int unsigned SYNC_W    = 15;
   localparam int unsigned CAP_DEPTH = 8;

   // =======================================================
   // Mode select encoding, {mode_sel_1, mode_sel_0}
   typedef enum logic [1:0]
   {
      USS_HOLD  = 2'h0,
      USS_SHR   = 2'h1,
      USS_SHL   = 2'h2,
      USS_LOAD  = 2'h3
   } uss_mode_t;

   // =======================================================
   // Register offsets (byte addresses)
   localparam logic [APB_AW-1:0] OFS_CTRL   = 8'h00;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
   localparam logic [APB_AW-1:0] OFS_DATA   = 8'h08;
   localparam logic [APB_AW-1:0] OFS_PINS   = 8'h0c;

   // =======================================================
   // Field positions
   localparam int unsigned CTRL_CAP_EN_BIT   = 0;
   localparam int unsigned STAT_EMPTY_BIT    = 8;
   localparam int unsigned STAT_FULL_BIT     = 9;
   localparam int unsigned STAT_OVF_BIT      = 10;
   localparam int unsigned DATA_VALID_BIT    = 8;
   localparam int unsigned PINS_OE_BIT       = 4;

   // =======================================================
   // Reset values
   localparam logic [STAGE_W-1:0] STAGE_RST  = 8'h00;
   localparam logic               CAP_EN_RST = 1'b0;
   localparam logic [SYNC_W-1:0]  SYNC_RST   = 15'h0000;

endpackage

// ==== uss_top.sv ====
`timescale 1ns/100ps
module uss_top
   import uss_pkg::*;
(
   // Clock and reset
   input  wire logic                   CLOCK,
   input  wire logic                   RST_N,
   // APB slave
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [uss_pkg::APB_AW-1:0]  PADDR,
   input  wire logic [uss_pkg::APB_DW-1:0]  PWDATA,
   output logic      [uss_pkg::APB_DW-1:0]  PRDATA,
   output logic                        PREADY,
   output logic                        PSLVERR,
   // Register pins
   input  wire logic                   SHIFT_CLOCK,
   input  wire logic                   MASTER_RESET_N,
   input  wire logic                   MODE_SEL_0,
   input  wire logic                   MODE_SEL_1,
   input  wire logic                   RIGHT_SERIAL_IN,
   input  wire logic                   LEFT_SERIAL_IN,
   input  wire logic                   OUT_EN_A_N,
   input  wire logic                   OUT_EN_B_N,
   // Shared parallel bus
   input  wire logic [uss_pkg::STAGE_W-1:0] PARALLEL_BUS_IN,
   output logic      [uss_pkg::STAGE_W-1:0] PARALLEL_BUS_OUT,
   output logic                        PARALLEL_BUS_OE,
   // Cascade taps
   output logic                        FIRST_STAGE_OUT,
   output logic                        LAST_STAGE_OUT
);
   import uss_pkg::*;

   // =======================================================
   // Pin synchronisers
   // Every register and bus pin except MASTER_RESET_N goes through the same two stages so the sampled
   // mode, serial and bus levels line up with the clock edge.
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic              shclk_prev_reg;
   wire  [SYNC_W-1:0] pin_raw = {SHIFT_CLOCK, MODE_SEL_1, MODE_SEL_0, RIGHT_SERIAL_IN,
                                 LEFT_SERIAL_IN, OUT_EN_A_N, OUT_EN_B_N, PARALLEL_BUS_IN};

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync1_reg      <= SYNC_RST;
         sync2_reg      <= SYNC_RST;
         shclk_prev_reg <= 1'b0;
      end
      else
      begin
         sync1_reg      <= pin_raw;
         sync2_reg      <= sync1_reg;
         shclk_prev_reg <= sync2_reg[14];
      end
   end

   wire               shclk_s = sync2_reg[14];
   wire uss_mode_t    mode_s  = uss_mode_t'(sync2_reg[13:12]);
   wire               rsi_s   = sync2_reg[11];
   wire               lsi_s   = sync2_reg[10];
   wire               oea_n_s = sync2_reg[9];
   wire               oeb_n_s = sync2_reg[8];
   wire [STAGE_W-1:0] bus_s   = sync2_reg[7:0];
   wire               shift_edge = shclk_s & ~shclk_prev_reg;

   // =======================================================
   // Stage register
   // Master reset clears at once but lets go only after two clock
   // edges, so the stage flops never see a release near an edge; the
   // pin must still be glitch-free since it clears without the clock.
   logic [STAGE_W-1:0] stage_reg;
   logic [STAGE_W-1:0] stage_next;
   logic [STAGE_W-1:0] stage_op;
   logic               bus_oe_reg;
   logic               mr_sync1_reg;
   logic               mr_sync2_reg;
   wire                mr_raw_n    = RST_N & MASTER_RESET_N;
   wire                stage_rst_n = mr_sync2_reg;

   always_ff @(posedge CLOCK or negedge mr_raw_n)
   begin
      if (!mr_raw_n)
      begin
         mr_sync1_reg <= 1'b0;
         mr_sync2_reg <= 1'b0;
      end
      else
      begin
         mr_sync1_reg <= 1'b1;
         mr_sync2_reg <= mr_sync1_reg;
      end
   end

   always_comb
   begin
      unique case (mode_s)
         USS_HOLD: stage_op = stage_reg;
         USS_SHR:  stage_op = {stage_reg[STAGE_W-2:0], rsi_s};
         USS_SHL:  stage_op = {lsi_s, stage_reg[STAGE_W-1:1]};
         USS_LOAD: stage_op = bus_s;
      endcase
   end

   assign stage_next = shift_edge ? stage_op : stage_reg;

   always_ff @(posedge CLOCK or negedge stage_rst_n)
   begin
      if (!stage_rst_n)
      begin
         stage_reg <= STAGE_RST;
      end
      else
      begin
         stage_reg <= stage_next;
      end
   end

   // =======================================================
   // Bus buffers and taps
   // Buffers never gate the stage logic, only the pin drive.
   wire bus_oe_next = ~oea_n_s & ~oeb_n_s & (mode_s != USS_LOAD);

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         bus_oe_reg <= 1'b0;
      end
      else
      begin
         bus_oe_reg <= bus_oe_next;
      end
   end

   assign PARALLEL_BUS_OUT = stage_reg;
   assign PARALLEL_BUS_OE  = bus_oe_reg;
   assign FIRST_STAGE_OUT  = stage_reg[0];
   assign LAST_STAGE_OUT   = stage_reg[STAGE_W-1];

   // =======================================================
   // Capture path into the FIFO
   // A pending word waits here while the FIFO is full; a further edge
   // in that time is dropped and flagged rather than stalling the pins.
   uss_fifo_if #(.WIDTH(STAGE_W)) cap_if ();

   logic               cap_en_reg;
   logic               pend_valid_reg;
   logic [STAGE_W-1:0] pend_data_reg;
   logic               ovf_reg;
   wire                cap_evt    = shift_edge & cap_en_reg & (mode_s != USS_HOLD);
   wire                pend_free  = ~pend_valid_reg | cap_if.in_ready;
   wire                pend_valid_next = cap_evt | (pend_valid_reg & ~cap_if.in_ready);
   wire [STAGE_W-1:0]  pend_data_next  = (cap_evt & pend_free) ? stage_op : pend_data_reg;
   wire                ovf_set    = cap_evt & ~pend_free;

   assign cap_if.in_valid = pend_valid_reg;
   assign cap_if.in_data  = pend_data_reg;

   uss_fifo #(.WIDTH(STAGE_W), .DEPTH(CAP_DEPTH)) u_fifo
   (
      .clock (CLOCK),
      .rst_n (RST_N),
      .port  (cap_if.store)
   );

   // =======================================================
   // APB decode
   wire                 setup_ph  = PSEL & ~PENABLE;
   wire                 access_ph = PSEL & PENABLE;
   wire                 hit_ctrl  = (PADDR == OFS_CTRL);
   wire                 hit_stat  = (PADDR == OFS_STATUS);
   wire                 hit_data  = (PADDR == OFS_DATA);
   wire                 hit_pins  = (PADDR == OFS_PINS);
   wire                 hit_any   = hit_ctrl | hit_stat | hit_data | hit_pins;
   wire                 wr_ctrl   = access_ph & PWRITE & hit_ctrl;
   wire                 wr_stat   = access_ph & PWRITE & hit_stat;
   wire                 ovf_clr   = wr_stat & PWDATA[STAT_OVF_BIT];
   wire                 ovf_next  = ovf_set | (ovf_reg & ~ovf_clr);
   wire [APB_DW-1:0]    rd_ctrl   = {31'h0, cap_en_reg};
   wire [APB_DW-1:0]    rd_stat   = {21'h0, ovf_reg, ~cap_if.in_ready,
                                     ~cap_if.out_valid, stage_reg};
   wire [APB_DW-1:0]    rd_data   = {23'h0, cap_if.out_valid, cap_if.out_data};
   wire [APB_DW-1:0]    rd_pins   = {27'h0, bus_oe_reg, oea_n_s, oeb_n_s, mode_s};
   wire [APB_DW-1:0]    rd_mux    = hit_ctrl ? rd_ctrl :
                                    hit_stat ? rd_stat :
                                    hit_data ? rd_data :
                                    hit_pins ? rd_pins : 32'h0000_0000;
   logic [APB_DW-1:0]   prdata_reg;

   // Read word is latched in setup; the pop lands on the access edge
   assign cap_if.out_ready = access_ph & ~PWRITE & hit_data;
   assign PREADY  = 1'b1;
   assign PSLVERR = access_ph & ~hit_any;
   assign PRDATA  = prdata_reg;

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cap_en_reg     <= CAP_EN_RST;
         pend_valid_reg <= 1'b0;
         pend_data_reg  <= STAGE_RST;
         ovf_reg        <= 1'b0;
         prdata_reg     <= 32'h0000_0000;
      end
      else
      begin
         if (wr_ctrl)
         begin
            cap_en_reg <= PWDATA[CTRL_CAP_EN_BIT];
         end
         if (setup_ph)
         begin
            prdata_reg <= rd_mux;
         end
         pend_valid_reg <= pend_valid_next;
         pend_data_reg  <= pend_data_next;
         ovf_reg        <= ovf_next;
      end
   end

   // =======================================================
   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!stage_rst_n);

   sequence s_edge_in(uss_mode_t m);
      shift_edge && mode_s == m;
   endsequence

   sequence s_released_shift;
      (oea_n_s || oeb_n_s) ##0 s_edge_in(USS_SHR);
   endsequence

   a_reset_clears_stages : assert property (disable iff (!RST_N)
      !MASTER_RESET_N |-> stage_reg == 8'h00)
      else $error("stages not cleared under master reset");

   a_load_copies_bus : assert property (
      s_edge_in(USS_LOAD) |=> stage_reg == $past(bus_s))
      else $error("load did not copy bus");

   a_shift_right_moves : assert property (
      s_edge_in(USS_SHR) |=> stage_reg == {$past(stage_reg[6:0]), $past(rsi_s)})
      else $error("right shift wrong");

   a_shift_left_moves : assert property (
      s_edge_in(USS_SHL) |=> stage_reg == {$past(lsi_s), $past(stage_reg[7:1])})
      else $error("left shift wrong");

   a_hold_keeps_state : assert property (
      mode_s == USS_HOLD |=> $stable(stage_reg))
      else $error("hold changed stages");

   a_no_edge_stable : assert property (
      !shift_edge ##1 !shift_edge |-> $stable(stage_reg))
      else $error("stages changed without clock edge");

   a_enable_high_off : assert property (
      (oea_n_s || oeb_n_s) |=> !PARALLEL_BUS_OE)
      else $error("bus driven while enable high");

   a_load_mode_off : assert property (
      mode_s == USS_LOAD |=> !PARALLEL_BUS_OE)
      else $error("bus driven in load mode");

   a_bus_drives_stage : assert property (
      !oea_n_s && !oeb_n_s && mode_s != USS_LOAD |=>
         PARALLEL_BUS_OE && PARALLEL_BUS_OUT == stage_reg)
      else $error("bus not driven with stage value");

   a_released_still_works : assert property (
      s_released_shift |=> stage_reg[0] == $past(rsi_s) && !PARALLEL_BUS_OE)
      else $error("stages idle while bus released");

   a_taps_follow_stage : assert property (
      FIRST_STAGE_OUT == stage_reg[0] && LAST_STAGE_OUT == stage_reg[7])
      else $error("cascade taps wrong");

   a_overflow_sticky : assert property (
      ovf_reg && !ovf_clr |=> ovf_reg)
      else $error("overflow flag lost");

   a_capture_takes_word : assert property (
      cap_evt && pend_free |=> pend_valid_reg && pend_data_reg == $past(stage_op))
      else $error("captured word not held");

   a_overflow_set_wins : assert property (
      ovf_set |=> ovf_reg)
      else $error("overflow set lost");
endmodule
